// ---- src/cmm_pkg.sv ----
// Package with register map, field layout and timing constants.
package cmm_pkg;

  // APB byte offsets.
  localparam logic [7:0] CMM_OFF_CONFIG = 8'h00;
  localparam logic [7:0] CMM_OFF_MAP    = 8'h04;
  localparam logic [7:0] CMM_OFF_TMSK   = 8'h08;
  localparam logic [7:0] CMM_OFF_OPTION = 8'h0C;
  localparam logic [7:0] CMM_OFF_MODE   = 8'h10;
  localparam logic [7:0] CMM_OFF_WDOG   = 8'h14;
  localparam logic [7:0] CMM_OFF_STATUS = 8'h18;
  localparam logic [7:0] CMM_OFF_MASK   = 8'h1C;
  localparam logic [7:0] CMM_OFF_DECODE = 8'h20;

  // Configuration byte fields.
  localparam int CMM_CFG_WDOG_DIS = 2;
  localparam int CMM_CFG_ROM_EN   = 1;
  localparam int CMM_CFG_EE_EN    = 0;
  localparam logic [7:0] CMM_CFG_ERASED = 8'h0F;
  localparam logic [7:0] CMM_CFG_IMPL   = 8'h0F;

  // Protected register reset values.
  localparam logic [3:0] CMM_RAM_PAGE_RST = 4'h0;
  localparam logic [3:0] CMM_REG_PAGE_RST = 4'h1;
  localparam logic [7:0] CMM_TMSK_RST     = 8'h00;
  localparam logic [7:0] CMM_OPTION_RST   = 8'h00;

  // Protection window.
  localparam int CMM_PROT_CYCLES = 64;

  // Watchdog service keys.
  localparam logic [7:0] CMM_WDOG_KEY1 = 8'h55;
  localparam logic [7:0] CMM_WDOG_KEY2 = 8'hAA;
  localparam int CMM_WDOG_TIMEOUT = 65536;

  // Memory windows.
  localparam logic [15:0] CMM_EE_BASE  = 16'hB600;
  localparam logic [15:0] CMM_EE_LAST  = 16'hB7FF;
  localparam logic [15:0] CMM_ROM_BASE = 16'hE000;
  localparam logic [7:0]  CMM_RAM_SIZE = 8'hFF;
  localparam logic [7:0]  CMM_REG_SIZE = 8'h3F;

  // Status bit positions.
  localparam int CMM_ST_WDOG_RST = 0;
  localparam int CMM_ST_PROT_REJ = 1;

  typedef enum logic [1:0] {
    CMM_SEL_NONE = 2'b00,
    CMM_SEL_ROM  = 2'b01,
    CMM_SEL_RAM  = 2'b10,
    CMM_SEL_REG  = 2'b11
  } cmm_sel_type;

  typedef struct packed {
    logic        reg_hit;
    logic        ram_hit;
    logic        rom_hit;
    logic        eeprom_hit;
    cmm_sel_type winner;
  } cmm_decode_type;

endpackage : cmm_pkg

// ---- src/cmm_wdog.sv ----
// Watchdog counter with two-key service sequence.
`timescale 1ns/1ps
module cmm_wdog
  import cmm_pkg::*;
#(
  parameter int TIMEOUT = CMM_WDOG_TIMEOUT
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Control.
  input  wire logic       enable,
  input  wire logic       key_valid,
  input  wire logic [7:0] key,
  // Result.
  output logic            timeout_pulse
);

  logic [31:0] count_q;
  logic        armed_q;

  // Apart from timeout and disable, the counter only restarts after both keys in order.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else if (key_valid) begin
      armed_q <= (key == CMM_WDOG_KEY1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_q       <= 32'h0;
      timeout_pulse <= 1'b0;
    end else begin
      timeout_pulse <= 1'b0;
      if (!enable) begin
        count_q <= 32'h0;
      end else if (key_valid && armed_q && key == CMM_WDOG_KEY2) begin
        count_q <= 32'h0;
      end else if (count_q == 32'(TIMEOUT - 1)) begin
        count_q       <= 32'h0;
        timeout_pulse <= 1'b1;
      end else begin
        count_q <= count_q + 32'h1;
      end
    end
  end

  a_wdog_off_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    !enable |=> !timeout_pulse) else $error("watchdog fired while off");

endmodule : cmm_wdog

// ---- src/cmm_ctrl.sv ----
// Configuration, memory map and protected register control block.
`timescale 1ns/1ps
module cmm_ctrl
  import cmm_pkg::*;
#(
  parameter int WDOG_TIMEOUT = CMM_WDOG_TIMEOUT
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Nonvolatile byte and operating mode.
  input  wire logic [7:0]  nv_config_byte,
  input  wire logic        special_mode_pin,
  input  wire logic        single_chip_pin,
  // CPU address for decode.
  input  wire logic [15:0] cpu_addr,
  // Decode and system outputs.
  output cmm_decode_type   decode,
  output logic [7:0]       timer_mask_two,
  output logic [7:0]       option_value,
  output logic             watchdog_reset,
  output logic             irq
);

  logic [7:0]  config_q;
  logic        cfg_loaded_q;
  logic [3:0]  ram_page_select_q;
  logic [3:0]  register_block_page_select_q;
  logic [7:0]  tmsk_q;
  logic [7:0]  option_q;
  logic        special_mode_flag_q;
  logic        mode_loaded_q;
  logic [2:0]  once_q;
  logic [6:0]  cycle_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        wr_en;
  logic        rd_en;
  logic        in_window;
  logic [2:0]  prot_hit;
  logic        prot_reject;
  logic        wdog_pulse;
  logic        cpu_rom_on;
  logic [1:0]  ev;
  cmm_decode_type dec_d;

  // Single-cycle access phase: zero wait states.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;

  // Strap sampling at release; single_chip_pin is not sampled and is used live during operation.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      config_q            <= CMM_CFG_ERASED;
      cfg_loaded_q        <= 1'b0;
      special_mode_flag_q <= 1'b0;
      mode_loaded_q       <= 1'b0;
    end else begin
      if (!cfg_loaded_q) begin
        config_q     <= nv_config_byte & CMM_CFG_IMPL;
        cfg_loaded_q <= 1'b1;
      end
      if (!mode_loaded_q) begin
        special_mode_flag_q <= special_mode_pin;
        mode_loaded_q       <= 1'b1;
      end else if (wr_en && paddr == CMM_OFF_MODE && !pwdata[0]) begin
        // The mode flag may only be cleared, never set again.
        special_mode_flag_q <= 1'b0;
      end
    end
  end

  // Bus-cycle counter for the protection window.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_q <= 7'h00;
    end else if (cycle_q != 7'(CMM_PROT_CYCLES)) begin
      cycle_q <= cycle_q + 7'h01;
    end
  end

  assign in_window = (cycle_q < 7'(CMM_PROT_CYCLES));

  function automatic logic allow_write(input logic special,
                                       input logic window,
                                       input logic used);
    allow_write = special || (window && !used);
  endfunction : allow_write

  // Only these three offsets are protected.
  assign prot_hit[0] = wr_en && paddr == CMM_OFF_MAP;
  assign prot_hit[1] = wr_en && paddr == CMM_OFF_TMSK;
  assign prot_hit[2] = wr_en && paddr == CMM_OFF_OPTION;

  always_comb begin
    prot_reject = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (prot_hit[i] &&
          !allow_write(special_mode_flag_q, in_window, once_q[i])) begin
        prot_reject = 1'b1;
      end
    end
  end

  // Protected registers; rejected writes are dropped and flagged in status.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ram_page_select_q            <= CMM_RAM_PAGE_RST;
      register_block_page_select_q <= CMM_REG_PAGE_RST;
      tmsk_q                       <= CMM_TMSK_RST;
      option_q                     <= CMM_OPTION_RST;
      once_q                       <= 3'h0;
    end else begin
      if (prot_hit[0] &&
          allow_write(special_mode_flag_q, in_window, once_q[0])) begin
        ram_page_select_q            <= pwdata[7:4];
        register_block_page_select_q <= pwdata[3:0];
        once_q[0]                    <= 1'b1;
      end
      if (prot_hit[1] &&
          allow_write(special_mode_flag_q, in_window, once_q[1])) begin
        tmsk_q    <= pwdata[7:0];
        once_q[1] <= 1'b1;
      end
      if (prot_hit[2] &&
          allow_write(special_mode_flag_q, in_window, once_q[2])) begin
        option_q  <= pwdata[7:0];
        once_q[2] <= 1'b1;
      end
    end
  end

  assign timer_mask_two = tmsk_q;
  assign option_value   = option_q;

  // Watchdog; disable bit gates the counter entirely.
  cmm_wdog #(
    .TIMEOUT (WDOG_TIMEOUT)
  ) u_wdog (
    .mclk          (mclk),
    .reset_n       (reset_n),
    .enable        (cfg_loaded_q && !config_q[CMM_CFG_WDOG_DIS]),
    .key_valid     (wr_en && paddr == CMM_OFF_WDOG),
    .key           (pwdata[7:0]),
    .timeout_pulse (wdog_pulse)
  );

  assign watchdog_reset = wdog_pulse;

  // ROM presence, forced on in normal single-chip mode.
  assign cpu_rom_on = config_q[CMM_CFG_ROM_EN] ||
                      (!special_mode_flag_q && single_chip_pin);

  // Address decode with priority: registers, then RAM, then ROM.
  always_comb begin
    dec_d.reg_hit = (cpu_addr[15:12] == register_block_page_select_q) &&
                    (cpu_addr[11:0] <= {4'h0, 2'b00, CMM_REG_SIZE[5:0]});
    dec_d.ram_hit = (cpu_addr[15:12] == ram_page_select_q) &&
                    (cpu_addr[11:8] == 4'h0) && !dec_d.reg_hit;
    dec_d.rom_hit = cpu_rom_on && (cpu_addr >= CMM_ROM_BASE) &&
                    !dec_d.reg_hit && !dec_d.ram_hit;
    dec_d.eeprom_hit = config_q[CMM_CFG_EE_EN] &&
                       (cpu_addr >= CMM_EE_BASE) &&
                       (cpu_addr <= CMM_EE_LAST) &&
                       !dec_d.reg_hit && !dec_d.ram_hit;
    if (dec_d.reg_hit) begin
      dec_d.winner = CMM_SEL_REG;
    end else if (dec_d.ram_hit) begin
      dec_d.winner = CMM_SEL_RAM;
    end else if (dec_d.rom_hit) begin
      dec_d.winner = CMM_SEL_ROM;
    end else begin
      dec_d.winner = CMM_SEL_NONE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      decode <= '0;
    end else begin
      decode <= dec_d;
    end
  end

  // Sticky events: set wins over write-one-to-clear.
  assign ev[CMM_ST_WDOG_RST] = wdog_pulse;
  assign ev[CMM_ST_PROT_REJ] = prot_reject;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 2'b00;
      mask_q   <= 2'b00;
    end else begin
      if (wr_en && paddr == CMM_OFF_STATUS) begin
        status_q <= (status_q & ~pwdata[1:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
      if (wr_en && paddr == CMM_OFF_MASK) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data is combinational and driven only while rd_en is high.
  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      case (paddr)
        CMM_OFF_CONFIG: prdata = {24'h0, config_q & CMM_CFG_IMPL};
        CMM_OFF_MAP:    prdata = {24'h0, ram_page_select_q,
                                  register_block_page_select_q};
        CMM_OFF_TMSK:   prdata = {24'h0, tmsk_q};
        CMM_OFF_OPTION: prdata = {24'h0, option_q};
        CMM_OFF_MODE:   prdata = {31'h0, special_mode_flag_q};
        CMM_OFF_STATUS: prdata = {30'h0, status_q};
        CMM_OFF_MASK:   prdata = {30'h0, mask_q};
        CMM_OFF_DECODE: prdata = {29'h0, in_window, once_q[1:0]};
        default:        prdata = 32'h0;
      endcase
    end
  end

  a_cfg_upper_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    config_q[7:4] == 4'h0) else $error("config upper bits set");
  a_cfg_copy_once: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_loaded_q |=> config_q == ($past(nv_config_byte) & 8'h0F))
    else $error("config not copied");
  a_late_map_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    prot_hit[0] && !special_mode_flag_q && !in_window |=>
    $stable(ram_page_select_q) && $stable(register_block_page_select_q))
    else $error("late map write took effect");
  a_once_map_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    prot_hit[0] && !special_mode_flag_q && once_q[0] |=>
    $stable(register_block_page_select_q)) else $error("second write");
  a_special_write: assert property (@(posedge mclk) disable iff (!reset_n)
    prot_hit[1] && special_mode_flag_q |=> tmsk_q == $past(pwdata[7:0]))
    else $error("special write lost");
  a_rom_forced_on: assert property (@(posedge mclk) disable iff (!reset_n)
    !special_mode_flag_q && single_chip_pin |-> cpu_rom_on)
    else $error("rom off in single chip");
  a_reg_over_ram: assert property (@(posedge mclk) disable iff (!reset_n)
    dec_d.reg_hit |=> decode.winner == CMM_SEL_REG && !decode.ram_hit)
    else $error("register block lost priority");
  a_eeprom_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !config_q[CMM_CFG_EE_EN] |=> !decode.eeprom_hit)
    else $error("eeprom decoded while off");
  a_window_closes: assert property (@(posedge mclk) disable iff (!reset_n)
    cycle_q == 7'd63 |=> !in_window) else $error("window length");

endmodule : cmm_ctrl

// ---- bench/cmm_ctrl_tb.sv ----
// Self-checking testbench for the configuration and memory map block.
`timescale 1ns/1ps
module cmm_ctrl_tb
  import cmm_pkg::*;
;
  localparam int TMO   = 64;
  localparam int LIMIT = 6000;

  logic           mclk;
  logic           reset_n;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  logic [7:0]     nv_config_byte;
  logic           special_mode_pin;
  logic           single_chip_pin;
  logic [15:0]    cpu_addr;
  cmm_decode_type decode;
  logic [7:0]     timer_mask_two;
  logic [7:0]     option_value;
  logic           watchdog_reset;
  logic           irq;
  int             bad_count;
  int             tests_run;
  int             cyc;
  logic           err_seen;
  logic [31:0]    q;
  logic           irq_a;
  int             n;

  // A short watchdog count keeps the timeout scenario brief.
  cmm_ctrl #(.WDOG_TIMEOUT(TMO)) uut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .nv_config_byte(nv_config_byte),
    .special_mode_pin(special_mode_pin),
    .single_chip_pin(single_chip_pin), .cpu_addr(cpu_addr),
    .decode(decode), .timer_mask_two(timer_mask_two),
    .option_value(option_value), .watchdog_reset(watchdog_reset),
    .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
    end
    r = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
    chk({31'h0, err_seen}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  // Decode is registered, so the result is looked at two edges later.
  task automatic dec(input logic [15:0] a, input cmm_sel_type w);
    cpu_addr <= a;
    repeat (2) @(posedge mclk);
    chk({30'h0, decode.winner}, {30'h0, w});
  endtask : dec

  task automatic rst(input logic [7:0] nv, input logic sp, input logic sc);
    @(posedge mclk);
    reset_n          <= 1'b0;
    nv_config_byte   <= nv;
    special_mode_pin <= sp;
    single_chip_pin  <= sc;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask : rst

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nv_config_byte = 8'hF9;
    special_mode_pin = 1'b0;
    single_chip_pin = 1'b0;
    cpu_addr = 16'h0000;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    // Watchdog on, ROM off, EEPROM on, upper stored bits set.
    rst(8'hF9, 1'b0, 1'b0);
    rd(CMM_OFF_CONFIG, 32'h09);
    dec(16'hE000, CMM_SEL_NONE);
    cpu_addr <= 16'hB600;
    repeat (2) @(posedge mclk);
    chk({31'h0, decode.eeprom_hit}, 32'h1);
    n = 0;
    while (watchdog_reset !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n < 300), 32'h1);
    apb(1'b0, CMM_OFF_STATUS, 32'h0, q);
    chk({31'h0, q[CMM_ST_WDOG_RST]}, 32'h1);
    wr(CMM_OFF_MASK, 32'h0);
    @(posedge mclk);
    irq_a = irq;
    wr(CMM_OFF_MASK, 32'h3);
    @(posedge mclk);
    chk({31'h0, irq_a ^ irq}, 32'h1);
    wr(CMM_OFF_WDOG, {24'h0, CMM_WDOG_KEY1});
    wr(CMM_OFF_WDOG, {24'h0, CMM_WDOG_KEY2});
    wr(CMM_OFF_STATUS, 32'h3);
    apb(1'b0, CMM_OFF_STATUS, 32'h0, q);
    chk({31'h0, q[CMM_ST_WDOG_RST]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Past the window a protected write is dropped but flagged.
    repeat (70) @(posedge mclk);
    wr(CMM_OFF_MAP, 32'h33);
    rd(CMM_OFF_MAP, 32'h01);
    apb(1'b0, CMM_OFF_STATUS, 32'h0, q);
    chk({31'h0, q[CMM_ST_PROT_REJ]}, 32'h1);
    // Erased byte, normal mode: each protected register takes one write.
    rst(8'h0F, 1'b0, 1'b0);
    rd(CMM_OFF_CONFIG, 32'h0F);
    wr(CMM_OFF_MAP, 32'hFF);
    wr(CMM_OFF_MAP, 32'h00);
    rd(CMM_OFF_MAP, 32'hFF);
    wr(CMM_OFF_TMSK, 32'h5A);
    wr(CMM_OFF_OPTION, 32'hA5);
    wr(CMM_OFF_TMSK, 32'h11);
    rd(CMM_OFF_TMSK, 32'h5A);
    chk({24'h0, timer_mask_two}, 32'h5A);
    chk({24'h0, option_value}, 32'hA5);
    dec(16'hF000, CMM_SEL_REG);
    dec(16'hF040, CMM_SEL_RAM);
    dec(16'hF100, CMM_SEL_ROM);
    n = 0;
    repeat (200) begin
      @(posedge mclk);
      if (watchdog_reset === 1'b1) begin
        n++;
      end
    end
    chk(n, 0);
    // Special mode, ROM and EEPROM off; ROM is forced on only when normal.
    rst(8'h0C, 1'b1, 1'b1);
    dec(16'hE000, CMM_SEL_NONE);
    cpu_addr <= 16'hB600;
    repeat (2) @(posedge mclk);
    chk({31'h0, decode.eeprom_hit}, 32'h0);
    single_chip_pin <= 1'b0;
    dec(16'hE000, CMM_SEL_NONE);
    repeat (70) @(posedge mclk);
    wr(CMM_OFF_MAP, 32'h23);
    wr(CMM_OFF_MAP, 32'h45);
    rd(CMM_OFF_MAP, 32'h45);
    wr(CMM_OFF_TMSK, 32'h77);
    wr(CMM_OFF_TMSK, 32'h78);
    rd(CMM_OFF_TMSK, 32'h78);
    wr(CMM_OFF_MODE, 32'h0);
    rd(CMM_OFF_MODE, 32'h0);
    single_chip_pin <= 1'b1;
    dec(16'hE000, CMM_SEL_ROM);
    wr(CMM_OFF_MAP, 32'h67);
    rd(CMM_OFF_MAP, 32'h45);
    rd(8'h3C, 32'h0);
    stop_test();
  end
endmodule : cmm_ctrl_tb
